// ---- logic/mcc_map.svh ----
/*
  Field codes, reset values and timing constants of the memory
  control configuration block. Assumes inclusion by its bare name.
*/
// Overview of operation
// - dram refresh holds row strobe 2..9 cycles from refresh_assert_len field
// - sdram auto-refresh blocks bank active for 4..11 plus precharge cycles
// - sdram always bursts; dram bursts only when burst_allow set
// - burst_allow and extended_out_sel pick single, fast page or edo for dram; sdram stays single
// - fast page only when access wider than bus width
// - mem_width_sel 10 gives 16 bits dram, 11 gives 32 bits
// - mem_width_sel overrides width from general bus control
// - dram column width 8..12 bits for mux codes 0..4
// - sdram bank select taken from address bits per mux code and ext
// - bank bits are logical external address bits, not pin numbers
// - refresh only while refresh_on set; reset value off
// - with refresh off the refresh timer serves as interval timer
// - refresh on, kind 0: periodic refresh on timer request
// - refresh request during bus cycle waits until cycle ends
// - refresh on, kind 1: wait for bus idle then self-refresh
// - periodic requests ignored while in self-refresh
// - extended_out_sel picks edo read sample point, dram only
// - post-refresh precharge 0..21 cycles in steps of 3
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH
`define MCC_RAS_BASE 4'h2
`define MCC_SDR_BASE 5'h04
`define MCC_PRE_STEP 5'h03
`define MCC_COL_BASE 4'h8
`define MCC_WID_16 2'h2
`define MCC_WID_32 2'h3
`define MCC_AMX_MAX 3'h4
`define MCC_RST_CFG 16'h0000
`endif

// ---- logic/mcc_pkg.sv ----
/*
  Types of the memory control configuration block.
  Assumes mcc_map.svh is on the include path.
*/
package mcc_pkg;
  typedef enum logic [2:0] {
    MCC_XFER_SINGLE = 3'h1,
    MCC_XFER_FPAGE = 3'h2,
    MCC_XFER_EDO = 3'h4
  } mcc_xfer_e;

  typedef enum logic [3:0] {
    MCC_ST_IDLE = 4'h1,
    MCC_ST_RAS = 4'h2,
    MCC_ST_HOLD = 4'h4,
    MCC_ST_SELF = 4'h8
  } mcc_state_e;

  typedef struct packed {
    logic [2:0] post_refresh_precharge;
    logic [2:0] refresh_assert_len;
    logic burst_allow;
    logic [1:0] mem_width_sel;
    logic addr_mux_ext;
    logic [2:0] addr_mux_code;
    logic refresh_on;
    logic refresh_kind;
    logic extended_out_sel;
  } mcc_cfg_s;
endpackage

// ---- logic/mcc_mem_ctl.sv ----
/*
  Memory control configuration and refresh sequencer for async dram
  or sdram. Config arrives as a struct of plain ports and is latched
  only while no external bus cycle runs. Assumes the bus engine gives
  i_bus_busy, the access size and the refresh timer request pulse.
*/
`timescale 1ns/100ps
`include "mcc_map.svh"
module mcc_mem_ctl
  import mcc_pkg::*;
#(
  parameter int ADDR_W = 26
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire mcc_cfg_s i_cfg,
  input wire logic i_is_sdram,
  input wire logic i_bus_busy,
  input wire logic [1:0] i_bcr_width,
  input wire logic [1:0] i_acc_size,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_refresh_req,
  output logic o_ras_refresh,
  output logic o_sdram_auto_ref,
  output logic o_sdram_self_ref,
  output logic o_act_block,
  output logic o_interval_tick,
  output logic o_burst,
  output mcc_xfer_e o_xfer_mode,
  output logic o_fast_page,
  output logic o_bus_is_32,
  output logic [3:0] o_col_bits,
  output logic [1:0] o_bank,
  output logic o_edo_sample,
  output logic o_cfg_err
);
  initial
  begin
    if (ADDR_W < 26)
      $error("ADDR_W must reach bit 25");
  end

  mcc_cfg_s cfg_reg, cfg_next;
  mcc_state_e st_reg, st_next;
  logic [4:0] cnt_reg, cnt_next;
  logic pend_reg, pend_next;
  logic ras_reg, ras_next, aref_reg, aref_next, self_reg, self_next;
  logic blk_reg, blk_next, tick_reg, tick_next;
  logic burst_reg, burst_next, fp_reg, fp_next, w32_reg, w32_next;
  logic edo_reg, edo_next, err_reg, err_next;
  mcc_xfer_e xm_reg, xm_next;
  logic [3:0] col_reg, col_next;
  logic [1:0] bank_reg, bank_next;
  logic [4:0] pre_cyc;

  // settings only move while the bus is idle, so no access sees a mix
  always_comb
  begin
    cfg_next = cfg_reg;
    if (!i_bus_busy)
      cfg_next = i_cfg;
  end

  // sdram post-refresh precharge, 3 cycles per step
  assign pre_cyc = 5'(cfg_reg.post_refresh_precharge * `MCC_PRE_STEP);

  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    pend_next = pend_reg;
    ras_next = 1'b0;
    aref_next = 1'b0;
    self_next = 1'b0;
    blk_next = 1'b0;
    tick_next = 1'b0;
    if (!cfg_reg.refresh_on)
    begin
      tick_next = i_refresh_req;
      pend_next = 1'b0;
      st_next = MCC_ST_IDLE;
    end
    else
    begin
      if (i_refresh_req && st_reg != MCC_ST_SELF)
        pend_next = 1'b1;
      unique case (st_reg)
        MCC_ST_IDLE:
        begin
          if (cfg_reg.refresh_kind && !i_bus_busy)
          begin
            st_next = MCC_ST_SELF;
            pend_next = 1'b0;
          end
          else if (!cfg_reg.refresh_kind && (pend_reg || i_refresh_req) && !i_bus_busy)
          begin
            pend_next = 1'b0;
            if (i_is_sdram)
            begin
              aref_next = 1'b1;
              blk_next = 1'b1;
              st_next = MCC_ST_HOLD;
              cnt_next = 5'(`MCC_SDR_BASE + {2'h0, cfg_reg.refresh_assert_len}
                + pre_cyc - 5'h01);
            end
            else
            begin
              ras_next = 1'b1;
              st_next = MCC_ST_RAS;
              cnt_next = 5'(`MCC_RAS_BASE + {1'b0, cfg_reg.refresh_assert_len}
                - 4'h1);
            end
          end
        end
        MCC_ST_RAS:
        begin
          if (cnt_reg == 5'h00)
            st_next = MCC_ST_IDLE;
          else
          begin
            ras_next = 1'b1;
            cnt_next = cnt_reg - 5'h01;
          end
        end
        MCC_ST_HOLD:
        begin
          if (cnt_reg == 5'h00)
            st_next = MCC_ST_IDLE;
          else
          begin
            blk_next = 1'b1;
            cnt_next = cnt_reg - 5'h01;
          end
        end
        MCC_ST_SELF:
        begin
          self_next = 1'b1;
          if (!cfg_reg.refresh_kind)
          begin
            self_next = 1'b0;
            st_next = MCC_ST_IDLE;
          end
        end
      endcase
    end
  end

  // transfer mode, width and address decode
  always_comb
  begin
    burst_next = i_is_sdram | cfg_reg.burst_allow;
    xm_next = MCC_XFER_SINGLE;
    if (!i_is_sdram && cfg_reg.burst_allow)
      xm_next = cfg_reg.extended_out_sel ? MCC_XFER_EDO : MCC_XFER_FPAGE;
    // mem_width_sel wins; bus control width only fills illegal codes
    if (cfg_reg.mem_width_sel == `MCC_WID_32)
      w32_next = 1'b1;
    else if (cfg_reg.mem_width_sel == `MCC_WID_16)
      w32_next = 1'b0;
    else
      w32_next = (i_bcr_width == `MCC_WID_32);
    // acc size 2 = 32 bit, 3 = 64 bit
    fp_next = (xm_next == MCC_XFER_FPAGE)
      && (w32_next ? (i_acc_size == 2'h3) : (i_acc_size[1]));
    col_next = `MCC_COL_BASE + {1'b0, cfg_reg.addr_mux_code};
    err_next = (!i_is_sdram && (cfg_reg.addr_mux_code > `MCC_AMX_MAX))
      || (!cfg_reg.burst_allow && cfg_reg.extended_out_sel)
      || !cfg_reg.mem_width_sel[1]
      || (i_is_sdram && cfg_reg.mem_width_sel != `MCC_WID_32)
      || (!i_is_sdram && cfg_reg.addr_mux_ext)
      || (i_is_sdram && cfg_reg.extended_out_sel);
    // bank bits index the logical byte address, not pin numbers
    unique case (cfg_reg.addr_mux_code)
      3'h0: bank_next = {1'b0, cfg_reg.addr_mux_ext ? i_addr[20] : i_addr[21]};
      3'h1: bank_next = {1'b0, cfg_reg.addr_mux_ext ? i_addr[21] : i_addr[22]};
      3'h2: bank_next = i_addr[23:22];
      3'h3: bank_next = i_addr[25:24];
      3'h4: bank_next = i_addr[23:22];
      3'h5: bank_next = {1'b0, i_addr[22]};
      3'h6: bank_next = i_addr[25:24];
      3'h7: bank_next = {1'b0, i_addr[20]};
    endcase
    if (!i_is_sdram)
      bank_next = 2'h0;
    edo_next = !i_is_sdram && cfg_reg.extended_out_sel;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cfg_reg <= `MCC_RST_CFG;
      st_reg <= MCC_ST_IDLE;
      cnt_reg <= 5'h00;
      pend_reg <= 1'b0;
      ras_reg <= 1'b0;
      aref_reg <= 1'b0;
      self_reg <= 1'b0;
      blk_reg <= 1'b0;
      tick_reg <= 1'b0;
      burst_reg <= 1'b0;
      xm_reg <= MCC_XFER_SINGLE;
      fp_reg <= 1'b0;
      w32_reg <= 1'b0;
      col_reg <= `MCC_COL_BASE;
      bank_reg <= 2'h0;
      edo_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
      ras_reg <= ras_next;
      aref_reg <= aref_next;
      self_reg <= self_next;
      blk_reg <= blk_next;
      tick_reg <= tick_next;
      burst_reg <= burst_next;
      xm_reg <= xm_next;
      fp_reg <= fp_next;
      w32_reg <= w32_next;
      col_reg <= col_next;
      bank_reg <= bank_next;
      edo_reg <= edo_next;
      err_reg <= err_next;
    end
  end

  assign o_ras_refresh = ras_reg;
  assign o_sdram_auto_ref = aref_reg;
  assign o_sdram_self_ref = self_reg;
  assign o_act_block = blk_reg;
  assign o_interval_tick = tick_reg;
  assign o_burst = burst_reg;
  assign o_xfer_mode = xm_reg;
  assign o_fast_page = fp_reg;
  assign o_bus_is_32 = w32_reg;
  assign o_col_bits = col_reg;
  assign o_bank = bank_reg;
  assign o_edo_sample = edo_reg;
  assign o_cfg_err = err_reg;
endmodule

// ---- test/mcc_mem_model.sv ----
/* Memory-side model: counts the cycles that refresh strobe and
   bank-active lockout are held. Assumes the controller's clock. */
`timescale 1ns/100ps
module mcc_mem_model
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ras,
  input wire logic i_act,
  output logic [7:0] o_ras_cnt,
  output logic [7:0] o_act_cnt
);
  // running totals; the bench takes differences per refresh
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_ras_cnt <= 8'h00;
      o_act_cnt <= 8'h00;
    end
    else
    begin
      o_ras_cnt <= o_ras_cnt + 8'(i_ras);
      o_act_cnt <= o_act_cnt + 8'(i_act);
    end
  end
endmodule

// ---- test/mcc_mem_ctl_props.sv ----
/* Port assertions for the memory control block.
   Assumes it is bound onto mcc_mem_ctl. */
`timescale 1ns/100ps
module mcc_mem_ctl_props
  import mcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_is_sdram,
  input wire logic i_bus_busy,
  input wire logic i_refresh_req,
  input wire logic o_ras_refresh,
  input wire logic o_sdram_auto_ref,
  input wire logic o_sdram_self_ref,
  input wire logic o_act_block,
  input wire logic o_interval_tick,
  input wire logic o_burst,
  input wire mcc_xfer_e o_xfer_mode,
  input wire logic o_fast_page
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // cycles the strobe has already been high; a counter keeps the long check cheap
  logic [3:0] ras_run;
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !o_ras_refresh)
      ras_run <= 4'h0;
    else if (ras_run != 4'hF)
      ras_run <= ras_run + 4'h1;
  end
  property p_ras_min; $rose(o_ras_refresh) |-> o_ras_refresh[*2]; endproperty
  a_ras_min: assert property (p_ras_min) else $error("strobe short");
  property p_ras_max; o_ras_refresh |-> ras_run < 4'h9; endproperty
  a_ras_max: assert property (p_ras_max) else $error("strobe long");
  property p_act_min; $rose(o_sdram_auto_ref) |-> o_act_block[*4]; endproperty
  a_act_min: assert property (p_act_min) else $error("lockout short");
  property p_aref; o_sdram_auto_ref |=> !o_sdram_auto_ref; endproperty
  a_aref: assert property (p_aref) else $error("auto refresh long");
  property p_burst; i_is_sdram[*3] |-> o_burst; endproperty
  a_burst: assert property (p_burst) else $error("sdram not burst");
  property p_mode; $onehot(o_xfer_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode code");
  property p_fpage; o_fast_page |-> o_xfer_mode == MCC_XFER_FPAGE; endproperty
  a_fpage: assert property (p_fpage) else $error("fast page mode");
  property p_defer; i_bus_busy |=> !$rose(o_ras_refresh) && !$rose(o_sdram_auto_ref); endproperty
  a_defer: assert property (p_defer) else $error("refresh in bus cycle");
  property p_self; o_sdram_self_ref |-> !o_ras_refresh && !o_sdram_auto_ref; endproperty
  a_self: assert property (p_self) else $error("refresh in self");
  property p_tick; o_interval_tick |-> $past(i_refresh_req); endproperty
  a_tick: assert property (p_tick) else $error("stray tick");
endmodule
bind mcc_mem_ctl mcc_mem_ctl_props u_props (.i_clk(i_clk), .i_reset(i_reset),
  .i_is_sdram(i_is_sdram), .i_bus_busy(i_bus_busy), .i_refresh_req(i_refresh_req),
  .o_ras_refresh(o_ras_refresh), .o_sdram_auto_ref(o_sdram_auto_ref),
  .o_sdram_self_ref(o_sdram_self_ref), .o_act_block(o_act_block),
  .o_interval_tick(o_interval_tick), .o_burst(o_burst), .o_xfer_mode(o_xfer_mode),
  .o_fast_page(o_fast_page));

// ---- test/tb.sv ----
/* Self-checking bench for mcc_mem_ctl with the memory model.
   Assumes the package and the map header are compiled first. */
`timescale 1ns/100ps
module tb;
  import mcc_pkg::*;
  logic i_clk, i_reset, i_is_sdram, i_bus_busy, i_refresh_req;
  logic [1:0] i_bcr_width, i_acc_size, bank;
  logic [25:0] i_addr;
  mcc_cfg_s cfg;
  logic ras, aref, sref, act, tick, burst, fpage, b32, edo, err;
  mcc_xfer_e xm;
  logic [3:0] col;
  logic [7:0] rc, ac, d, a, t, r0;
  int err_total, total_checks;
  mcc_mem_ctl u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_cfg(cfg), .i_is_sdram(i_is_sdram),
    .i_bus_busy(i_bus_busy), .i_bcr_width(i_bcr_width), .i_acc_size(i_acc_size),
    .i_addr(i_addr), .i_refresh_req(i_refresh_req), .o_ras_refresh(ras),
    .o_sdram_auto_ref(aref), .o_sdram_self_ref(sref), .o_act_block(act),
    .o_interval_tick(tick), .o_burst(burst), .o_xfer_mode(xm), .o_fast_page(fpage),
    .o_bus_is_32(b32), .o_col_bits(col), .o_bank(bank), .o_edo_sample(edo), .o_cfg_err(err));
  mcc_mem_model u_mem (.i_clk(i_clk), .i_reset(i_reset), .i_ras(ras), .i_act(act),
    .o_ras_cnt(rc), .o_act_cnt(ac));
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // 40 cycles covers the longest lockout of 32
  task automatic req(output logic [7:0] dr, output logic [7:0] da, output logic [7:0] dt);
    logic [7:0] ra, aa;
    ra = rc;
    aa = ac;
    i_refresh_req = 1'b1;
    tk(1);
    dt = 8'(tick);
    i_refresh_req = 1'b0;
    tk(40);
    dr = rc - ra;
    da = ac - aa;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    {i_reset, i_is_sdram, i_bus_busy, i_refresh_req} = 4'h8;
    {i_bcr_width, i_acc_size, i_addr, cfg} = '0;
    err_total = 0;
    total_checks = 0;
    tk(10);
    i_reset = 1'b0;
    tk(1);
    chk(xm, 8'h01);
    req(d, a, t);
    chk(d, 8'h00);
    chk(t, 8'h01);
    cfg.refresh_on = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      cfg.refresh_assert_len = 3'(k);
      tk(3);
      req(d, a, t);
      chk(d, 8'(2 + k));
      chk(t, 8'h00);
    end
    i_is_sdram = 1'b1;
    cfg.mem_width_sel = 2'h3;
    for (int k = 0; k < 8; k++)
    begin
      cfg.refresh_assert_len = 3'(k);
      cfg.post_refresh_precharge = 3'(k);
      tk(3);
      req(d, a, t);
      chk(a, 8'(4 + 4 * k));
    end
    i_is_sdram = 1'b0;
    cfg.refresh_assert_len = 3'h0;
    tk(3);
    i_bus_busy = 1'b1;
    req(d, a, t);
    chk(d, 8'h00);
    r0 = rc;
    i_bus_busy = 1'b0;
    tk(12);
    chk(rc - r0, 8'h02);
    // held off by a running bus cycle, settings stay the old ones
    i_bus_busy = 1'b1;
    cfg.refresh_kind = 1'b1;
    tk(5);
    chk(sref, 8'h00);
    i_bus_busy = 1'b0;
    tk(3);
    chk(sref, 8'h01);
    req(d, a, t);
    chk(d, 8'h00);
    cfg = '0;
    cfg.mem_width_sel = 2'h3;
    for (int i = 0; i < 3; i++)
    begin
      cfg.burst_allow = i > 0;
      cfg.extended_out_sel = i == 2;
      tk(3);
      chk(xm, 8'h01 << i);
      chk(edo, 8'(i == 2));
    end
    cfg.burst_allow = 1'b0;
    tk(3);
    chk(err, 8'h01);
    cfg.burst_allow = 1'b1;
    cfg.extended_out_sel = 1'b0;
    for (int j = 2; j < 4; j++)
    begin
      cfg.mem_width_sel = 2'(j);
      i_bcr_width = 2'(5 - j);
      tk(3);
      chk(b32, 8'(j == 3));
      for (int s = 0; s < 4; s++)
      begin
        i_acc_size = 2'(s);
        tk(2);
        chk(fpage, 8'(s >= j));
      end
    end
    for (int c = 0; c < 5; c++)
    begin
      cfg.addr_mux_code = 3'(c);
      tk(3);
      chk(col, 8'(8 + c));
    end
    i_is_sdram = 1'b1;
    cfg.burst_allow = 1'b0;
    i_addr = 26'h1800000;
    cfg.addr_mux_code = 3'h2;
    tk(3);
    chk(bank, 8'h02);
    chk(burst, 8'h01);
    cfg.addr_mux_code = 3'h6;
    tk(3);
    chk(bank, 8'h01);
    wrap_up();
  end
endmodule
